// ===== iolf_line_config.sv
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Line 1 codes 0-6, reset disabled
// - Line 2: clock in, ADC, general purpose
// - Line 3: slave select input or ADC
// - Line 4: codes 0,1,3-5; data input
// - Line 5 default drives blinking association LED
// - Line 7 code 6: transmit enable low-active
// - Line 7 code 7: high-active; reset CTS
// - Line 10: strength PWM or channel A
// - Line 11: slow clock or channel B
// - Line 12 code 1: data output
// - Line 13: disabled or UART transmit data
// - Line 14: disabled or UART receive data
// - Pull direction bits, 1 up, reset zero
// - Pull enable bits, reset all set
// - Pulls act only on inputs or disabled
// - Pull bit to line mapping
// - Channel A duty 10 bits, reset zero
// - Channel B duty 10 bits, reset zero
// - Zero blink time: 500 or 250 ms
// - Blink time in 10 ms, 0x14 up
// - Strength PWM hold in 100 ms units
// - Hold value 0xFF never times out
module iolf_line_config #(
    parameter int TICK_CYCLES = iolf_pkg::TICK_CYCLES
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic cmd_wr,
    input wire logic cmd_rd,
    input wire logic [4:0] cmd_idx,
    input wire logic [15:0] cmd_wdata,
    output logic cmd_ack_q,
    output logic cmd_err_q,
    output logic [15:0] cmd_rdata_q,
    input wire logic [14:0] pad_in,
    output logic [14:0] line_in_q,
    output logic [14:0] pad_out_q,
    output logic [14:0] pad_oe_n_q,
    output logic [14:0] pad_pull_en_q,
    output logic [14:0] pad_pull_up_q,
    output logic [14:0] pad_adc_sel_q,
    input wire logic spi_attention_out,
    input wire logic uart_data_present,
    input wire logic cts_ready,
    input wire logic tx_active,
    input wire logic on_sleep,
    input wire logic spi_miso_data,
    input wire logic uart_tx_data,
    input wire logic associated,
    input wire logic sleep_coordinator,
    input wire logic [9:0] signal_strength,
    input wire logic strength_update
);
    // Reject tick counts the counter cannot hold
    if (TICK_CYCLES < 1 || TICK_CYCLES > 16777215)
    begin : g_bad_tick
        $error("TICK_CYCLES out of range");
    end

    // Is a selector code offered on this line
    function automatic logic code_ok(input int line, input logic [7:0] code);
        logic ok;
        ok = 1'b0;
        case (line)
            1: ok = (code <= iolf_pkg::FN_ALT6);
            2, 3, 10, 11: ok = (code <= iolf_pkg::FN_HIGH);
            7: ok = (code <= iolf_pkg::FN_ALT7) && (code != iolf_pkg::FN_ADC);
            13, 14: ok = (code <= iolf_pkg::FN_ALT);
            default: ok = (code <= iolf_pkg::FN_HIGH) && (code != iolf_pkg::FN_ADC);
        endcase
        return ok;
    endfunction

    // Selector reset value for each line; the rest reset disabled
    function automatic logic [7:0] sel_reset(input int line);
        return (line inside {5, 7, 8, 9, 10, 13, 14}) ? iolf_pkg::FN_ALT
            : iolf_pkg::FN_DISABLED;
    endfunction

    // Line owning a pull bit
    function automatic int pull_line(input int bit_idx);
        return int'(iolf_pkg::PULL_LINE_MAP[bit_idx*4 +: 4]);
    endfunction

    // Pulls act only on inputs and disabled lines
    function automatic logic pulls_apply(input logic [7:0] code);
        return (code == iolf_pkg::FN_DISABLED) || (code == iolf_pkg::FN_DIN);
    endfunction

    // Settings; line 0 has no selector and stays disabled
    logic [7:0] sel_q [0:14];
    logic [14:0] pull_dir_q;
    logic [14:0] pull_en_q;
    logic [9:0] pwm_a_q;
    logic [9:0] pwm_b_q;
    logic [7:0] blink_q;
    logic [7:0] hold_q;
    // Command decode results
    logic wr_ok;
    logic rd_ok;
    int idx_int;

    assign idx_int = int'(cmd_idx);

    // Write acceptance per target; bad values leave the setting alone
    always_comb
    begin
        wr_ok = 1'b0;
        if (cmd_idx >= iolf_pkg::IDX_LINE_FIRST && cmd_idx <= iolf_pkg::IDX_LINE_LAST)
            wr_ok = (cmd_wdata <= iolf_pkg::BYTE_MAX)
                && code_ok(idx_int, cmd_wdata[7:0]);
        else if (cmd_idx == iolf_pkg::IDX_PULL_DIR || cmd_idx == iolf_pkg::IDX_PULL_EN)
            wr_ok = (cmd_wdata <= iolf_pkg::MASK_MAX);
        else if (cmd_idx == iolf_pkg::IDX_PWM_A || cmd_idx == iolf_pkg::IDX_PWM_B)
            wr_ok = (cmd_wdata <= iolf_pkg::DUTY_MAX);
        // Zero means default rate; other values start at the floor
        else if (cmd_idx == iolf_pkg::IDX_BLINK)
            wr_ok = (cmd_wdata <= iolf_pkg::BYTE_MAX) && ((cmd_wdata[7:0] == 8'h00)
                || (cmd_wdata[7:0] >= iolf_pkg::BLINK_MIN));
        else if (cmd_idx == iolf_pkg::IDX_HOLD)
            wr_ok = (cmd_wdata <= iolf_pkg::BYTE_MAX);
    end

    // Any known index can be read
    assign rd_ok = (cmd_idx >= iolf_pkg::IDX_LINE_FIRST) && (cmd_idx <= iolf_pkg::IDX_HOLD);

    // Selector storage
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            for (int i = 0; i < iolf_pkg::NUM_LINES; i++)
                sel_q[i] <= sel_reset(i);
        else if (cmd_wr && wr_ok && cmd_idx <= iolf_pkg::IDX_LINE_LAST)
            sel_q[idx_int] <= cmd_wdata[7:0];
    end

    // Pull, PWM, blink and hold storage
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pull_dir_q <= iolf_pkg::PULL_DIR_RST;
            pull_en_q <= iolf_pkg::PULL_EN_RST;
            pwm_a_q <= iolf_pkg::PWM_DUTY_RST;
            pwm_b_q <= iolf_pkg::PWM_DUTY_RST;
            blink_q <= iolf_pkg::BLINK_RST;
            hold_q <= iolf_pkg::HOLD_RST;
        end
        else if (cmd_wr && wr_ok)
        begin
            if (cmd_idx == iolf_pkg::IDX_PULL_DIR)
                pull_dir_q <= cmd_wdata[14:0];
            else if (cmd_idx == iolf_pkg::IDX_PULL_EN)
                pull_en_q <= cmd_wdata[14:0];
            else if (cmd_idx == iolf_pkg::IDX_PWM_A)
                pwm_a_q <= cmd_wdata[9:0];
            else if (cmd_idx == iolf_pkg::IDX_PWM_B)
                pwm_b_q <= cmd_wdata[9:0];
            else if (cmd_idx == iolf_pkg::IDX_BLINK)
                blink_q <= cmd_wdata[7:0];
            else if (cmd_idx == iolf_pkg::IDX_HOLD)
                hold_q <= cmd_wdata[7:0];
        end
    end

    // Command answer: one-cycle ack or error, read data held until the next accepted read
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cmd_ack_q <= 1'b0;
            cmd_err_q <= 1'b0;
            cmd_rdata_q <= 16'h0000;
        end
        else
        begin
            // Write has priority when both strobes arrive together
            cmd_ack_q <= (cmd_wr && wr_ok) || (!cmd_wr && cmd_rd && rd_ok);
            cmd_err_q <= (cmd_wr && !wr_ok) || (!cmd_wr && cmd_rd && !rd_ok);
            if (!cmd_wr && cmd_rd && rd_ok)
            begin
                if (cmd_idx <= iolf_pkg::IDX_LINE_LAST)
                    cmd_rdata_q <= {8'h00, sel_q[idx_int]};
                else if (cmd_idx == iolf_pkg::IDX_PULL_DIR)
                    cmd_rdata_q <= {1'b0, pull_dir_q};
                else if (cmd_idx == iolf_pkg::IDX_PULL_EN)
                    cmd_rdata_q <= {1'b0, pull_en_q};
                else if (cmd_idx == iolf_pkg::IDX_PWM_A)
                    cmd_rdata_q <= {6'h00, pwm_a_q};
                else if (cmd_idx == iolf_pkg::IDX_PWM_B)
                    cmd_rdata_q <= {6'h00, pwm_b_q};
                else if (cmd_idx == iolf_pkg::IDX_BLINK)
                    cmd_rdata_q <= {8'h00, blink_q};
                else
                    cmd_rdata_q <= {8'h00, hold_q};
            end
        end
    end

    // Two-stage synchroniser on the pads
    logic [14:0] pad_meta_q;
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pad_meta_q <= 15'h0000;
            line_in_q <= 15'h0000;
        end
        else
        begin
            pad_meta_q <= pad_in;
            line_in_q <= pad_meta_q;
        end
    end

    // Shared 1024-step PWM timebase
    logic [9:0] pwm_cnt_q;
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            pwm_cnt_q <= 10'h000;
        else
            pwm_cnt_q <= pwm_cnt_q + 10'h001;
    end

    // Slow clock: half period rounded to whole cycles, so about 32.8 kHz
    logic [8:0] slow_cnt_q;
    logic slow_clk_q;
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            slow_cnt_q <= 9'h000;
            slow_clk_q <= 1'b0;
        end
        else if (slow_cnt_q == iolf_pkg::SLOW_HALF_CYCLES - 9'h001)
        begin
            slow_cnt_q <= 9'h000;
            slow_clk_q <= !slow_clk_q;
        end
        else
        begin
            slow_cnt_q <= slow_cnt_q + 9'h001;
        end
    end

    // 10 ms tick enable
    logic [23:0] tick_cnt_q;
    logic tick_q;
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            tick_cnt_q <= 24'h000000;
            tick_q <= 1'b0;
        end
        else if (tick_cnt_q == 24'(TICK_CYCLES - 1))
        begin
            tick_cnt_q <= 24'h000000;
            tick_q <= 1'b1;
        end
        else
        begin
            tick_cnt_q <= tick_cnt_q + 24'h000001;
            tick_q <= 1'b0;
        end
    end

    // Association LED: equal on and off times, dark when not associated
    logic [7:0] led_half;
    logic [7:0] led_cnt_q;
    logic led_q;
    assign led_half = (blink_q != 8'h00) ? blink_q
        : (sleep_coordinator ? iolf_pkg::LED_COORD_TICKS : iolf_pkg::LED_NODE_TICKS);
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            led_cnt_q <= 8'h00;
            led_q <= 1'b0;
        end
        else if (!associated)
        begin
            led_cnt_q <= 8'h00;
            led_q <= 1'b0;
        end
        else if (tick_q)
        begin
            // Compare with >= so a shorter new setting takes effect at once
            if (led_cnt_q >= led_half - 8'h01)
            begin
                led_cnt_q <= 8'h00;
                led_q <= !led_q;
            end
            else
                led_cnt_q <= led_cnt_q + 8'h01;
        end
    end

    // Strength PWM hold: reloaded by each update, counts down in 100 ms units
    logic [7:0] hold_cnt_q;
    logic [3:0] hold_sub_q;
    logic [9:0] strength_q;
    logic strength_on;
    assign strength_on = (hold_q == iolf_pkg::HOLD_FOREVER) || (hold_cnt_q != 8'h00);
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            hold_cnt_q <= 8'h00;
            hold_sub_q <= 4'h0;
            strength_q <= 10'h000;
        end
        else if (strength_update)
        begin
            hold_cnt_q <= hold_q;
            hold_sub_q <= 4'h0;
            strength_q <= signal_strength;
        end
        else if (tick_q && hold_cnt_q != 8'h00 && hold_q != iolf_pkg::HOLD_FOREVER)
        begin
            if (hold_sub_q == iolf_pkg::HOLD_UNIT_TICKS - 4'h1)
            begin
                hold_sub_q <= 4'h0;
                hold_cnt_q <= hold_cnt_q - 8'h01;
            end
            else
                hold_sub_q <= hold_sub_q + 4'h1;
        end
    end

    // Alternate-function output level per line and whether it drives
    logic [14:0] alt_val;
    logic [14:0] alt_drv;
    always_comb
    begin
        alt_val = 15'h0000;
        alt_drv = 15'h0000;
        // Plain drive codes first; function codes below override them
        for (int l = 1; l < iolf_pkg::NUM_LINES; l++)
        begin
            alt_drv[l] = (sel_q[l] == iolf_pkg::FN_LOW) || (sel_q[l] == iolf_pkg::FN_HIGH);
            alt_val[l] = (sel_q[l] == iolf_pkg::FN_HIGH);
        end
        // Function codes 1, 6 and 7, and code 2 on lines 10-11: outputs only; inputs stay undriven
        case (sel_q[1])
            iolf_pkg::FN_ALT: {alt_drv[1], alt_val[1]} = {1'b1, spi_attention_out};
            iolf_pkg::FN_ALT6: {alt_drv[1], alt_val[1]} = {1'b1, uart_data_present};
            default: ;
        endcase
        if (sel_q[5] == iolf_pkg::FN_ALT)
            {alt_drv[5], alt_val[5]} = {1'b1, led_q};
        case (sel_q[7])
            iolf_pkg::FN_ALT: {alt_drv[7], alt_val[7]} = {1'b1, cts_ready};
            iolf_pkg::FN_ALT6: {alt_drv[7], alt_val[7]} = {1'b1, !tx_active};
            iolf_pkg::FN_ALT7: {alt_drv[7], alt_val[7]} = {1'b1, tx_active};
            default: ;
        endcase
        if (sel_q[9] == iolf_pkg::FN_ALT)
            {alt_drv[9], alt_val[9]} = {1'b1, on_sleep};
        case (sel_q[10])
            iolf_pkg::FN_ALT: {alt_drv[10], alt_val[10]} =
                {1'b1, strength_on && (pwm_cnt_q < strength_q)};
            iolf_pkg::FN_ADC: {alt_drv[10], alt_val[10]} =
                {1'b1, pwm_cnt_q < pwm_a_q};
            default: ;
        endcase
        case (sel_q[11])
            iolf_pkg::FN_ALT: {alt_drv[11], alt_val[11]} = {1'b1, slow_clk_q};
            iolf_pkg::FN_ADC: {alt_drv[11], alt_val[11]} =
                {1'b1, pwm_cnt_q < pwm_b_q};
            default: ;
        endcase
        if (sel_q[12] == iolf_pkg::FN_ALT)
            {alt_drv[12], alt_val[12]} = {1'b1, spi_miso_data};
        if (sel_q[13] == iolf_pkg::FN_ALT)
            {alt_drv[13], alt_val[13]} = {1'b1, uart_tx_data};
    end

    // Registered pad controls
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pad_out_q <= 15'h0000;
            pad_oe_n_q <= 15'h7FFF;
            pad_pull_en_q <= 15'h0000;
            pad_pull_up_q <= 15'h0000;
            pad_adc_sel_q <= 15'h0000;
        end
        else
        begin
            pad_out_q <= alt_val;
            pad_oe_n_q <= ~alt_drv;
            // Direction shows only while the pull is on, so an idle pull reads as none
            for (int b = 0; b < iolf_pkg::NUM_LINES; b++)
            begin
                pad_pull_en_q[pull_line(b)] <= pulls_apply(sel_q[pull_line(b)])
                    && pull_en_q[b];
                pad_pull_up_q[pull_line(b)] <= pulls_apply(sel_q[pull_line(b)])
                    && pull_en_q[b] && pull_dir_q[b];
            end
            for (int l = 0; l < iolf_pkg::NUM_LINES; l++)
                pad_adc_sel_q[l] <= (sel_q[l] == iolf_pkg::FN_ADC) && (l <= 3);
        end
    end
endmodule

`default_nettype wire

// ===== iolf_pkg.sv
package iolf_pkg;
    // Number of I/O lines handled, line 0 to line 14
    localparam int NUM_LINES = 15;
    // Command-port register indices; selectors use their own line number
    localparam logic [4:0] IDX_LINE_FIRST = 5'h01;
    localparam logic [4:0] IDX_LINE_LAST = 5'h0E;
    localparam logic [4:0] IDX_PULL_DIR = 5'h0F;
    localparam logic [4:0] IDX_PULL_EN = 5'h10;
    localparam logic [4:0] IDX_PWM_A = 5'h11;
    localparam logic [4:0] IDX_PWM_B = 5'h12;
    localparam logic [4:0] IDX_BLINK = 5'h13;
    localparam logic [4:0] IDX_HOLD = 5'h14;
    // Selector codes shared by all lines
    localparam logic [7:0] FN_DISABLED = 8'h00;
    localparam logic [7:0] FN_ALT = 8'h01;
    localparam logic [7:0] FN_ADC = 8'h02;
    localparam logic [7:0] FN_DIN = 8'h03;
    localparam logic [7:0] FN_LOW = 8'h04;
    localparam logic [7:0] FN_HIGH = 8'h05;
    localparam logic [7:0] FN_ALT6 = 8'h06;
    localparam logic [7:0] FN_ALT7 = 8'h07;
    // Reset values of the other settings
    localparam logic [14:0] PULL_DIR_RST = 15'h0000;
    localparam logic [14:0] PULL_EN_RST = 15'h7FFF;
    localparam logic [9:0] PWM_DUTY_RST = 10'h000;
    localparam logic [7:0] BLINK_RST = 8'h00;
    localparam logic [7:0] HOLD_RST = 8'h28;
    // Value limits
    localparam logic [15:0] DUTY_MAX = 16'h03FF;
    localparam logic [15:0] MASK_MAX = 16'h7FFF;
    localparam logic [15:0] BYTE_MAX = 16'h00FF;
    localparam logic [7:0] BLINK_MIN = 8'h14;
    localparam logic [7:0] HOLD_FOREVER = 8'hFF;
    // Timing
    localparam int CLK_HZ = 25000000;
    localparam int TICK_MS = 10;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam int LED_COORD_MS = 500;
    localparam int LED_NODE_MS = 250;
    localparam logic [7:0] LED_COORD_TICKS = 8'(LED_COORD_MS / TICK_MS);
    localparam logic [7:0] LED_NODE_TICKS = 8'(LED_NODE_MS / TICK_MS);
    localparam int HOLD_UNIT_MS = 100;
    localparam logic [3:0] HOLD_UNIT_TICKS = 4'(HOLD_UNIT_MS / TICK_MS);
    localparam int SLOW_CLK_HZ = 32768;
    localparam logic [8:0] SLOW_HALF_CYCLES = 9'(CLK_HZ / (2 * SLOW_CLK_HZ));
    // Pull bit to line map
    localparam logic [59:0] PULL_LINE_MAP = {
        4'd13, 4'd7, 4'd11, 4'd10, 4'd12, 4'd9, 4'd5, 4'd14,
        4'd8, 4'd6, 4'd0, 4'd1, 4'd2, 4'd3, 4'd4};
endpackage

// ===== iolf_chk.sv
`timescale 1ns/1ps
`default_nettype none
// Watches the command port and pad gating from the ports alone
module iolf_chk (
    input wire logic clk,
    input wire logic nrst,
    input wire logic cmd_wr,
    input wire logic cmd_rd,
    input wire logic [4:0] cmd_idx,
    input wire logic [15:0] cmd_wdata,
    input wire logic cmd_ack_q,
    input wire logic cmd_err_q,
    input wire logic [14:0] pad_oe_n_q,
    input wire logic [14:0] pad_pull_en_q,
    input wire logic [14:0] pad_pull_up_q
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // Every taken command gets exactly one of the two answers next cycle
    one_answer_a:
        assert property ((cmd_wr || cmd_rd) |=> cmd_ack_q != cmd_err_q) else $error("no answer");
    bad_index_a:
        assert property ((cmd_wr || cmd_rd) && (cmd_idx == 5'h0 || cmd_idx > 5'h14) |=> cmd_err_q)
        else $error("bad index taken");
    duty_range_a:
        assert property (cmd_wr && cmd_idx inside {5'h11, 5'h12} && cmd_wdata > 16'h3FF
            |=> cmd_err_q) else $error("duty above range taken");
    blink_floor_a:
        assert property (cmd_wr && cmd_idx == 5'h13 && cmd_wdata inside {[1:19]} |=> cmd_err_q)
        else $error("short blink taken");
    line4_adc_a:
        assert property (cmd_wr && cmd_idx == 5'h4 && cmd_wdata == 16'h2 |=> cmd_err_q)
        else $error("line 4 code 2 taken");
    uart_codes_a:
        assert property (cmd_wr && cmd_idx inside {5'hD, 5'hE} && cmd_wdata > 16'h1 |=> cmd_err_q)
        else $error("uart line code taken");
    // Pulls must be off wherever the line is driven, and pull-up set only while the pull is on
    pull_gate_a:
        assert property ((pad_pull_en_q & ~pad_oe_n_q) == 15'h0) else $error("pull on driven line");
    dir_gate_a:
        assert property ((pad_pull_up_q & ~pad_pull_en_q) == 15'h0) else $error("pull-up while off");
endmodule
`default_nettype wire

// ===== iolf_pads.sv
`timescale 1ns/1ps
`default_nettype none
// External circuit on the pads: driven pad, outside driver, pull, else floating
module iolf_pads (
    input wire logic clk,
    input wire logic [14:0] pad_out_q,
    input wire logic [14:0] pad_oe_n_q,
    input wire logic [14:0] pad_pull_en_q,
    input wire logic [14:0] pad_pull_up_q,
    input wire logic [14:0] ext_en,
    input wire logic [14:0] ext_lvl,
    output logic [14:0] pad_in
);
    // Floating lines wobble so no settled level can be mistaken for a pull
    logic [14:0] wob = 15'h0;
    always @(posedge clk) wob <= ~wob;
    // Pad level resolution, pull resistor last
    always_comb
        for (int i = 0; i < 15; i++)
            pad_in[i] = !pad_oe_n_q[i] ? pad_out_q[i] : ext_en[i] ? ext_lvl[i] :
                pad_pull_en_q[i] ? pad_pull_up_q[i] : wob[i];
endmodule
`default_nettype wire

// ===== iolf_line_config_tb.sv
`timescale 1ns/1ps
`default_nettype none
module iolf_line_config_tb;
    // Legal code masks, reset values, pull bit of each line
    localparam logic [7:0] LM [15] = '{8'h0, 8'h7F, 8'h3F, 8'h3F, 8'h3B, 8'h3B, 8'h3B, 8'hFB,
        8'h3B, 8'h3B, 8'h3F, 8'h3F, 8'h3B, 8'h3, 8'h3};
    localparam logic [15:0] RV [21] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h1, 16'h0, 16'h1,
        16'h1, 16'h1, 16'h1, 16'h0, 16'h0, 16'h1, 16'h1, 16'h0, 16'h7FFF, 16'h0, 16'h0, 16'h0,
        16'h28};
    localparam int LB [15] = '{4, 3, 2, 1, 0, 8, 5, 13, 6, 9, 11, 12, 10, 14, 7};
    localparam logic [4:0] CI [10] = '{5'h13, 5'h13, 5'h11, 5'h11, 5'h4, 5'h7, 5'hD, 5'h0,
        5'h15, 5'hB};
    localparam logic [15:0] CD [10] = '{16'h13, 16'h14, 16'h400, 16'h3FF, 16'h2, 16'h7, 16'h2,
        16'h0, 16'h0, 16'h2};
    localparam logic [15:0] MK [4] = '{16'h7, 16'hFFFF, 16'h3FF, 16'h1F};
    localparam logic [15:0] PC [4] = '{16'h2, 16'h3, 16'h4, 16'h5};
    localparam int FL [6] = '{1, 1, 7, 7, 12, 13};
    localparam int FC [6] = '{1, 6, 6, 7, 1, 1};
    localparam int FB [6] = '{0, 1, 3, 3, 5, 6};
    localparam int FI [6] = '{0, 0, 1, 0, 0, 0};
    localparam int GL [4] = '{5, 5, 5, 11};
    localparam logic [15:0] GB [4] = '{16'h14, 16'h0, 16'h0, 16'h0};
    localparam int GE [4] = '{200, 250, 500, 381};
    logic clk = 1'b0, nrst = 1'b0, cmd_wr = 1'b0, cmd_rd = 1'b0, su = 1'b0;
    logic assoc = 1'b0, coord = 1'b0, cmd_ack_q, cmd_err_q;
    logic [4:0] cmd_idx = 5'h0;
    logic [15:0] cmd_wdata = 16'h0, cmd_rdata_q;
    logic [9:0] ss = 10'h3FF;
    logic [6:0] core = 7'h0, cp = 7'h0;
    logic [14:0] ext_en = 15'h0, ext_lvl = 15'h0, pad_in, pad_out_q, pad_oe_n_q;
    logic [14:0] pad_pull_en_q, pad_pull_up_q, line_in_q, pad_adc_sel_q;
    logic [15:0] sh [21];
    int seed = 32'h7BD9655B, seed_b = 32'h7BD9655B, compares = 0, miscompares = 0;
    iolf_line_config #(.TICK_CYCLES(10)) iolf_line_config_inst (.clk(clk), .nrst(nrst),
        .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_idx(cmd_idx), .cmd_wdata(cmd_wdata),
        .cmd_ack_q(cmd_ack_q), .cmd_err_q(cmd_err_q), .cmd_rdata_q(cmd_rdata_q),
        .pad_in(pad_in), .line_in_q(line_in_q), .pad_out_q(pad_out_q), .pad_oe_n_q(pad_oe_n_q),
        .pad_pull_en_q(pad_pull_en_q), .pad_pull_up_q(pad_pull_up_q),
        .pad_adc_sel_q(pad_adc_sel_q),
        .spi_attention_out(core[0]), .uart_data_present(core[1]), .cts_ready(core[2]),
        .tx_active(core[3]), .on_sleep(core[4]), .spi_miso_data(core[5]),
        .uart_tx_data(core[6]), .associated(assoc), .sleep_coordinator(coord),
        .signal_strength(ss), .strength_update(su));
    iolf_pads iolf_pads_inst (.clk(clk), .pad_out_q(pad_out_q), .pad_oe_n_q(pad_oe_n_q),
        .pad_pull_en_q(pad_pull_en_q), .pad_pull_up_q(pad_pull_up_q), .ext_en(ext_en),
        .ext_lvl(ext_lvl), .pad_in(pad_in));
    always #20 clk = ~clk;
    // Core levels and outside drivers change every falling edge; cp keeps the last value
    always @(negedge clk)
    begin
        cp <= core;
        core <= 7'($random(seed_b));
        ext_en <= 15'($random(seed_b));
        ext_lvl <= 15'($random(seed_b));
    end
    task automatic conclude;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        compares++;
        if (g !== e)
        begin
            miscompares++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask
    function automatic logic legal(input logic [4:0] i, input logic [15:0] d);
        if (i >= 5'h1 && i <= 5'hE)
            return d < 16'h8 && LM[i][d[2:0]];
        if (i == 5'hF || i == 5'h10)
            return d <= 16'h7FFF;
        if (i == 5'h11 || i == 5'h12)
            return d <= 16'h3FF;
        if (i == 5'h13)
            return d == 16'h0 || (d >= 16'h14 && d <= 16'hFF);
        return i == 5'h14 && d <= 16'hFF;
    endfunction
    // One command; the answer stands in the cycle after the taking edge
    task automatic xfer(input logic w, input logic [4:0] i, input logic [15:0] d);
        @(negedge clk);
        cmd_wr = w;
        cmd_rd = !w;
        cmd_idx = i;
        cmd_wdata = d;
        @(negedge clk);
        cmd_wr = 1'b0;
        cmd_rd = 1'b0;
    endtask
    // Write, check the answer, read back what should be held
    task automatic put(input logic [4:0] i, input logic [15:0] d);
        logic ok;
        ok = legal(i, d);
        xfer(1'b1, i, d);
        chk({cmd_ack_q, cmd_err_q}, {ok, !ok});
        if (ok)
            sh[i] = d;
        xfer(1'b0, i, 16'h0);
        if (ok)
            chk(cmd_rdata_q, sh[i]);
    endtask
    task automatic hi(input int l, input int m, output int n);
        n = 0;
        repeat (m)
        begin
            @(negedge clk);
            n += int'(pad_out_q[l] === 1'b1);
        end
    endtask
    // Cycles between two toggles of a pad, bounded
    task automatic gap(input int l, output int n);
        logic v;
        for (int p = 0; p < 2; p++)
        begin
            n = 0;
            v = pad_out_q[l];
            while (n < 3000 && pad_out_q[l] === v)
            begin
                @(negedge clk);
                n++;
            end
        end
        if (n == 3000)
        begin
            miscompares++;
            conclude();
        end
    endtask
    task automatic pulse;
        @(negedge clk);
        su = 1'b1;
        @(negedge clk);
        su = 1'b0;
    endtask
    initial
    begin
        #4000000;
        miscompares++;
        conclude();
    end
    initial
    begin
        logic [15:0] c;
        logic a;
        int n;
        sh = RV;
        repeat (3) @(negedge clk);
        nrst = 1'b1;
        for (int i = 1; i < 21; i++)
        begin
            xfer(1'b0, 5'(i), 16'h0);
            chk(cmd_rdata_q, RV[i]);
        end
        for (int k = 0; k < 10; k++)
            put(CI[k], CD[k]);
        for (int k = 0; k < 300; k++)
            put(5'($unsigned($random(seed)) % 23), 16'($random(seed)) & MK[k % 4]);
        // Random codes 2-5 on lines 1-12, codes 0 or 1 on lines 13-14, and pulls, all at once
        put(5'hF, 16'($random(seed)) & 16'h7FFF);
        put(5'h10, 16'($random(seed)) & 16'h7FFF);
        for (int l = 1; l < 15; l++)
            put(5'(l), l > 12 ? 16'($random(seed) & 1) : PC[2'($random(seed))]);
        for (int l = 0; l < 15; l++)
        begin
            c = l > 0 ? sh[l] : 16'h0;
            a = c == 16'h0 || c == 16'h3;
            chk(pad_pull_en_q[l], a & sh[16][LB[l]]);
            chk(pad_pull_up_q[l], a & sh[16][LB[l]] & sh[15][LB[l]]);
            chk(pad_adc_sel_q[l], c == 16'h2 && l < 4);
            if (c == 16'h4 || c == 16'h5)
                chk({pad_oe_n_q[l], pad_out_q[l], line_in_q[l]},
                    {1'b0, c == 16'h5, c == 16'h5});
        end
        // Alternate outputs follow their core signal
        for (int k = 0; k < 6; k++)
        begin
            put(5'(FL[k]), 16'(FC[k]));
            repeat (8)
            begin
                @(negedge clk);
                #1;
                chk({pad_oe_n_q[FL[k]], pad_out_q[FL[k]]}, {1'b0, cp[FB[k]] ^ FI[k][0]});
            end
        end
        for (int k = 0; k < 6; k++)
        begin
            c = k % 3 == 0 ? 16'h0 : k % 3 == 1 ? 16'h3FF : 16'($random(seed)) & 16'h3FF;
            put(5'(17 + k / 3), c);
            put(5'(10 + k / 3), 16'h2);
            repeat (1030) @(negedge clk);
            hi(10 + k / 3, 1024, n);
            chk(16'(n), c);
        end
        assoc = 1'b1;
        for (int k = 0; k < 4; k++)
        begin
            coord = k == 2;
            put(5'h13, GB[k]);
            put(5'(GL[k]), 16'h1);
            gap(GL[k], n);
            chk(16'(n), 16'(GE[k]));
        end
        assoc = 1'b0;
        repeat (3) @(negedge clk);
        chk({pad_oe_n_q[5], pad_out_q[5]}, 16'h0);
        put(5'h14, 16'h2);
        put(5'hA, 16'h1);
        pulse();
        hi(10, 150, n);
        chk(16'(n > 100), 16'h1);
        hi(10, 100, n);
        hi(10, 1100, n);
        chk(16'(n), 16'h0);
        put(5'h14, 16'hFF);
        pulse();
        repeat (26000) @(negedge clk);
        hi(10, 1024, n);
        chk(16'(n), 16'h3FF);
        conclude();
    end
endmodule
bind iolf_line_config iolf_chk iolf_chk_inst (.clk(clk), .nrst(nrst), .cmd_wr(cmd_wr),
    .cmd_rd(cmd_rd), .cmd_idx(cmd_idx), .cmd_wdata(cmd_wdata), .cmd_ack_q(cmd_ack_q),
    .cmd_err_q(cmd_err_q), .pad_oe_n_q(pad_oe_n_q), .pad_pull_en_q(pad_pull_en_q),
    .pad_pull_up_q(pad_pull_up_q));
`default_nettype wire
